// ### inc/icsr_pkg.sv
// shared constants and types of the indexed register path and main status register
package icsr_pkg;

  // ---------------------------------------------------------------
  // host port select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PORT_INDEX = 2'h0;
  localparam logic [1:0] PORT_MAIN = 2'h1;
  localparam logic [1:0] PORT_BUSCFG = 2'h2;

  // ---------------------------------------------------------------
  // index port
  // ---------------------------------------------------------------
  localparam int INDEX_W = 7;
  localparam logic [6:0] INDEX_RESET = 7'h00;
  localparam logic [6:0] IDX_MAIN_STATUS = 7'h00;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h03;

  // ---------------------------------------------------------------
  // main status register bit positions
  // ---------------------------------------------------------------
  localparam int BIT_ERR = 15;
  localparam int BIT_OVL = 14;
  localparam int BIT_SQE = 13;
  localparam int BIT_LOST = 12;
  localparam int BIT_BUSTO = 11;
  localparam int BIT_RXD = 10;
  localparam int BIT_TXD = 9;
  localparam int BIT_INITD = 8;
  localparam int BIT_IRQ_SUM = 7;
  localparam int BIT_IEN = 6;
  localparam int BIT_RX_ON = 5;
  localparam int BIT_TX_ON = 4;
  localparam int BIT_POLL = 3;
  localparam int BIT_STOP = 2;
  localparam int BIT_RUN = 1;
  localparam int BIT_INIT = 0;
  localparam logic [6:0] FLAGS_RESET = 7'h00;

  // ---------------------------------------------------------------
  // interrupt mask register
  // ---------------------------------------------------------------
  localparam logic [15:0] MASK_WR_BITS = 16'h5F00;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 100;
  localparam int SQE_WINDOW_BITS = 20;
  localparam int SQE_WINDOW_NS = SQE_WINDOW_BITS * BIT_TIME_NS;
  localparam int SQE_WINDOW_CYC = (SQE_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DMA_TIMEOUT_US = 50;
  localparam int DMA_TIMEOUT_CYC = (DMA_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;
  localparam logic [10:0] OVERLENGTH_BYTES = 11'h5EF;
  localparam logic [10:0] BYTE_CNT_RESET = 11'h000;

  // ---------------------------------------------------------------
  // run sequencing states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ICSR_HALTED = 2'b00,
    ICSR_INIT_WAIT = 2'b01,
    ICSR_RUN = 2'b11
  } icsr_run_t;

endpackage

// ### design/icsr_timer.sv
// armed timeout counter that pulses when its limit passes uncancelled
`timescale 1ns/1ns
module icsr_timer #(
  parameter int LIMIT = 250
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic cancel,
  output logic expire
);
  import icsr_pkg::*;

  localparam logic [TIMER_W-1:0] LAST = TIMER_W'(LIMIT - 1);

  logic running;
  logic [TIMER_W-1:0] count;
  wire at_last = running && (count == LAST);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= at_last && !cancel;
      if (cancel || at_last) begin
        running <= 1'b0;
        count <= '0;
      end else if (arm) begin
        running <= 1'b1;
        count <= '0;
      end else if (running) begin
        count <= count + TIMER_W'(1);
      end
    end
  end

endmodule // icsr_timer

// ### design/icsr_top.sv
// index port, data port routing and main status/control register
`timescale 1ns/1ns
// Function
// - index is 7 bits, upper bits read zero, cleared by reset
// - main data port reaches control registers, second port reaches bus-config registers
// - bit 15 is read-only OR of the four error flags
// - overlength flag sets when 1519 or more bytes go out in one frame
// - bits 14 to 8 clear on written one, reset or stop
// - collision-test flag sets on missing collision pulse or link fail while transmitting in twisted pair
// - collision-test flag feeds error summary but never the interrupt
// - lost-frame flag sets when a frame is dropped for lack of descriptor
// - bus timeout flag sets when acknowledge is missing 50 us after request
// - receive-done flag sets after frame received and last buffer returned
// - transmit-done flag sets after frame sent and last buffer returned
// - init-done flag sets when the init block has been read
// - bit 7 is OR of unmasked sources, cleared with causes, reset, stop
// - interrupt output active only with summary set and enable one
// - bit 6 enable is read/write, cleared by reset or stop
// - six sources raise interrupt only while their mask bit is clear
// - poll-now bit forces ring poll, resets at once when transmitter is off
// - poll-now ignores written zero, clears on descriptor fetch
// - stop bit set by one or reset, cleared by start/init, overrides both
// - mask bits clear on reset and ignore stop
module icsr_top #(
  parameter int DMA_TIMEOUT = icsr_pkg::DMA_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic [6:0] reg_index,
  output logic ext_csr_wr,
  output logic ext_csr_rd,
  output logic ext_bus_cfg_wr,
  output logic ext_bus_cfg_rd,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] ext_csr_rdata,
  input wire logic [15:0] ext_bus_cfg_rdata,
  input wire logic tx_frame_start,
  input wire logic tx_byte,
  input wire logic tx_frame_end,
  input wire logic col_pin,
  input wire logic tp_mode,
  input wire logic link_fail,
  input wire logic tx_busy,
  input wire logic lost_frame_evt,
  input wire logic dma_req,
  input wire logic dack_pin,
  input wire logic rx_done_evt,
  input wire logic tx_done_evt,
  input wire logic init_read_done,
  input wire logic ext_irq_src,
  input wire logic rx_disable,
  input wire logic tx_disable,
  input wire logic tx_desc_fetch,
  output logic irq,
  output logic run_request,
  output logic init_request,
  output logic stopped,
  output logic rx_active,
  output logic tx_active,
  output logic tx_poll_now,
  output logic [15:0] irq_mask_reg
);
  import icsr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [6:0] flags;
  logic irq_master_enable;
  logic [10:0] tx_byte_count;
  logic col_meta;
  logic col_sync;
  logic dack_meta;
  logic dack_sync;
  logic dma_req_q;
  logic sqe_expire;
  logic dma_expire;
  icsr_run_t run_state;
  icsr_run_t next_run_state;
  logic [6:0] next_flags;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire sel_index = host_sel == PORT_INDEX;
  wire sel_main = host_sel == PORT_MAIN;
  wire sel_buscfg = host_sel == PORT_BUSCFG;
  wire hit_status = sel_main && (reg_index == IDX_MAIN_STATUS);
  wire hit_mask = sel_main && (reg_index == IDX_IRQ_MASK);
  wire hit_other = sel_main && !hit_status && !hit_mask;
  wire wr_index = host_wr && sel_index;
  wire wr_status = host_wr && hit_status;
  wire wr_mask = host_wr && hit_mask;
  wire stop_set = wr_status && host_wdata[BIT_STOP];
  wire run_set = wr_status && host_wdata[BIT_RUN] && !host_wdata[BIT_STOP];
  wire init_set = wr_status && host_wdata[BIT_INIT] && !host_wdata[BIT_STOP];
  wire [6:0] w1c = wr_status ? host_wdata[BIT_OVL:BIT_INITD] : 7'h00;

  assign ext_csr_wr = host_wr && hit_other;
  assign ext_csr_rd = host_rd && hit_other;
  assign ext_bus_cfg_wr = host_wr && sel_buscfg;
  assign ext_bus_cfg_rd = host_rd && sel_buscfg;
  assign ext_wdata = host_wdata;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_meta <= 1'b0;
      col_sync <= 1'b0;
      dack_meta <= 1'b0;
      dack_sync <= 1'b0;
    end else begin
      col_meta <= col_pin;
      col_sync <= col_meta;
      dack_meta <= dack_pin;
      dack_sync <= dack_meta;
    end
  end

  // ---------------------------------------------------------------
  // index port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_index <= INDEX_RESET;
    end else if (wr_index) begin
      reg_index <= host_wdata[INDEX_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  wire ovl_hit = tx_byte && (tx_byte_count == OVERLENGTH_BYTES - 11'h001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_byte_count <= BYTE_CNT_RESET;
    end else if (tx_frame_start) begin
      tx_byte_count <= BYTE_CNT_RESET;
    end else if (tx_byte && tx_byte_count != OVERLENGTH_BYTES) begin
      tx_byte_count <= tx_byte_count + 11'h001;
    end
  end

  icsr_timer #(
    .LIMIT(SQE_WINDOW_CYC)
  ) u_sqe_timer (
    .clk(clk),
    .rst(rst),
    .arm(tx_frame_end),
    .cancel(col_sync),
    .expire(sqe_expire)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_req_q <= 1'b0;
    end else begin
      dma_req_q <= dma_req;
    end
  end

  icsr_timer #(
    .LIMIT(DMA_TIMEOUT)
  ) u_dma_timer (
    .clk(clk),
    .rst(rst),
    .arm(dma_req && !dma_req_q),
    .cancel(dack_sync || !dma_req),
    .expire(dma_expire)
  );

  wire sqe_evt = sqe_expire || (tp_mode && link_fail && tx_busy);
  wire [6:0] evt_set = {ovl_hit, sqe_evt, lost_frame_evt, dma_expire,
    rx_done_evt, tx_done_evt, init_read_done};

  // ---------------------------------------------------------------
  // error and completion flags
  // ---------------------------------------------------------------
  always_comb begin
    next_flags = (stop_set ? FLAGS_RESET : (flags & ~w1c)) | evt_set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // mask register and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= host_wdata & MASK_WR_BITS;
    end
  end

  wire [6:0] src_enable = {~irq_mask_reg[BIT_OVL], 1'b0,
    ~irq_mask_reg[BIT_LOST:BIT_INITD]};
  wire err_summary = |flags[6:3];
  wire irq_summary = |(flags & src_enable) || (ext_irq_src && !stopped);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_master_enable <= 1'b0;
    end else if (stop_set) begin
      irq_master_enable <= 1'b0;
    end else if (wr_status) begin
      irq_master_enable <= host_wdata[BIT_IEN];
    end
  end

  assign irq = irq_summary && irq_master_enable;

  // ---------------------------------------------------------------
  // stop, start and init
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stopped <= 1'b1;
      run_request <= 1'b0;
      init_request <= 1'b0;
    end else if (stop_set) begin
      stopped <= 1'b1;
      run_request <= 1'b0;
      init_request <= 1'b0;
    end else begin
      if (run_set || init_set) begin
        stopped <= 1'b0;
      end
      if (run_set) begin
        run_request <= 1'b1;
      end
      if (init_set) begin
        init_request <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive and transmit enable sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      ICSR_HALTED: begin
        if (run_set && init_set) begin
          next_run_state = ICSR_INIT_WAIT;
        end else if (run_set) begin
          next_run_state = ICSR_RUN;
        end
      end
      ICSR_INIT_WAIT: begin
        if (init_read_done) begin
          next_run_state = ICSR_RUN;
        end
      end
      ICSR_RUN: begin
        next_run_state = ICSR_RUN;
      end
      default: begin
        next_run_state = ICSR_HALTED;
      end
    endcase
    if (stop_set) begin
      next_run_state = ICSR_HALTED;
    end
  end

  wire entering_run = (next_run_state == ICSR_RUN) && (run_state != ICSR_RUN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_state <= ICSR_HALTED;
      rx_active <= 1'b0;
      tx_active <= 1'b0;
    end else begin
      run_state <= next_run_state;
      if (stop_set) begin
        rx_active <= 1'b0;
        tx_active <= 1'b0;
      end else if (entering_run) begin
        rx_active <= !rx_disable;
        tx_active <= !tx_disable;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit poll demand
  // ---------------------------------------------------------------
  wire poll_set = wr_status && host_wdata[BIT_POLL] && !host_wdata[BIT_STOP];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_poll_now <= 1'b0;
    end else if (stop_set || !tx_active) begin
      tx_poll_now <= 1'b0;
    end else if (poll_set) begin
      tx_poll_now <= 1'b1;
    end else if (tx_desc_fetch) begin
      tx_poll_now <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [15:0] status_word = {err_summary, flags, irq_summary, irq_master_enable,
    rx_active, tx_active, tx_poll_now, stopped, run_request, init_request};
  wire [15:0] index_word = {9'h000, reg_index};
  wire [15:0] rd_word = sel_index ? index_word :
    hit_status ? status_word :
    hit_mask ? irq_mask_reg :
    hit_other ? ext_csr_rdata :
    sel_buscfg ? ext_bus_cfg_rdata : 16'h0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_rdata <= 16'h0000;
    end else if (host_rd) begin
      host_rdata <= rd_word;
    end
  end

endmodule // icsr_top

// ### bench/icsr_ext_regs_model.sv
// model of the registers reached behind the two data ports
`timescale 1ns/1ns
module icsr_ext_regs_model (
  input wire logic clk,
  input wire logic [6:0] reg_index,
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] wdata,
  output logic [15:0] csr_rdata,
  output logic [15:0] cfg_rdata
);
  logic [15:0] csr_mem [128];
  logic [15:0] cfg_mem [128];
  always_ff @(posedge clk) begin
    if (csr_wr) csr_mem[reg_index] <= wdata;
    if (cfg_wr) cfg_mem[reg_index] <= wdata;
  end
  // a port not being read shows the inverted word
  assign csr_rdata = csr_rd ? csr_mem[reg_index] : ~csr_mem[reg_index];
  assign cfg_rdata = cfg_rd ? cfg_mem[reg_index] : ~cfg_mem[reg_index];
endmodule // icsr_ext_regs_model

// ### bench/icsr_checker.sv
// concurrent checks on the ports of the register path
`timescale 1ns/1ns
module icsr_checker
  import icsr_pkg::*;
#(
  parameter int DMA_TIMEOUT = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] host_sel,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic [6:0] reg_index,
  input wire logic ext_csr_wr,
  input wire logic ext_bus_cfg_rd,
  input wire logic tx_desc_fetch,
  input wire logic irq,
  input wire logic stopped,
  input wire logic run_request,
  input wire logic rx_active,
  input wire logic tx_active,
  input wire logic tx_poll_now
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire st_wr = host_wr && host_sel == PORT_MAIN && reg_index == IDX_MAIN_STATUS;
  wire st_rd = host_rd && host_sel == PORT_MAIN && reg_index == IDX_MAIN_STATUS;
  wire ix_wr = host_wr && host_sel == PORT_INDEX;
  property p_idx;
    ix_wr |=> reg_index == $past(host_wdata[6:0]);
  endproperty
  a_idx: assert property (p_idx) else $error("index not loaded");
  property p_idx_rd;
    host_rd && host_sel == PORT_INDEX |=> host_rdata == {9'h000, $past(reg_index)};
  endproperty
  a_idx_rd: assert property (p_idx_rd) else $error("index read wrong");
  property p_keep;
    !ix_wr |=> $stable(reg_index);
  endproperty
  a_keep: assert property (p_keep) else $error("index changed");
  property p_csr;
    ext_csr_wr == (host_wr && host_sel == PORT_MAIN && reg_index != IDX_MAIN_STATUS
      && reg_index != IDX_IRQ_MASK);
  endproperty
  a_csr: assert property (p_csr) else $error("main port routing wrong");
  property p_cfg;
    ext_bus_cfg_rd == (host_rd && host_sel == PORT_BUSCFG);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config port routing wrong");
  property p_err;
    st_rd |=> host_rdata[BIT_ERR] == (|host_rdata[14:11]);
  endproperty
  a_err: assert property (p_err) else $error("error summary wrong");
  property p_irq;
    st_rd |=> (host_rdata[BIT_IRQ_SUM] && host_rdata[BIT_IEN]) == $past(irq);
  endproperty
  a_irq: assert property (p_irq) else $error("irq output wrong");
  property p_stop;
    st_wr && host_wdata[BIT_STOP] |=> stopped && !run_request && !rx_active && !irq;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
  property p_start;
    st_wr && host_wdata[BIT_RUN] && !host_wdata[BIT_STOP] |=> !stopped && run_request;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_poll;
    tx_poll_now |-> tx_active;
  endproperty
  a_poll: assert property (p_poll) else $error("poll while transmitter off");
  property p_fetch;
    tx_desc_fetch && !(st_wr && host_wdata[BIT_POLL]) |=> !tx_poll_now;
  endproperty
  a_fetch: assert property (p_fetch) else $error("poll not cleared");
  property p_rx_active;
    rx_active |-> run_request && !stopped;
  endproperty
  a_rx_active: assert property (p_rx_active) else $error("receive on while halted");
endmodule // icsr_checker
bind icsr_top icsr_checker #(.DMA_TIMEOUT(DMA_TIMEOUT)) chk_u (.clk(clk), .rst(rst),
  .host_sel(host_sel), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
  .host_rdata(host_rdata), .reg_index(reg_index), .ext_csr_wr(ext_csr_wr),
  .ext_bus_cfg_rd(ext_bus_cfg_rd), .tx_desc_fetch(tx_desc_fetch), .irq(irq),
  .stopped(stopped), .run_request(run_request), .rx_active(rx_active),
  .tx_active(tx_active), .tx_poll_now(tx_poll_now));

// ### bench/test_indexed_csr_status_irq.sv
// self-checking bench of the register path and status register
`timescale 1ns/1ns
module test_indexed_csr_status_irq;
  import icsr_pkg::*;
  localparam int DMA_T = 20;
  logic clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
  logic [1:0] host_sel = 2'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic [7:0] ev = 8'h00;
  logic col_pin = 1'b0, tp_mode = 1'b0, link_fail = 1'b0, tx_busy = 1'b0;
  logic dma_req = 1'b0, dack_pin = 1'b0, rx_disable = 1'b0, tx_disable = 1'b1;
  logic ext_irq = 1'b0;
  logic [15:0] host_rdata, ext_wdata, csr_rd_d, cfg_rd_d, irq_mask_reg;
  logic [6:0] reg_index;
  logic c_wr, c_rd, b_wr, b_rd, irq, run_request, init_request, stopped;
  logic rx_active, tx_active, tx_poll_now;
  int n_errors = 0, tests_run = 0;
  int eb[3] = '{3, 5, 6};
  logic [15:0] ef[3] = '{16'h9000, 16'h0200, 16'h0100};
  always #4 clk = ~clk;
  icsr_top #(.DMA_TIMEOUT(DMA_T)) dut_u (.clk(clk), .rst(rst), .host_sel(host_sel),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .reg_index(reg_index), .ext_csr_wr(c_wr), .ext_csr_rd(c_rd), .ext_bus_cfg_wr(b_wr),
    .ext_bus_cfg_rd(b_rd), .ext_wdata(ext_wdata), .ext_csr_rdata(csr_rd_d),
    .ext_bus_cfg_rdata(cfg_rd_d), .tx_frame_start(ev[0]), .tx_byte(ev[1]),
    .tx_frame_end(ev[2]), .col_pin(col_pin), .tp_mode(tp_mode), .link_fail(link_fail),
    .tx_busy(tx_busy), .lost_frame_evt(ev[3]), .dma_req(dma_req), .dack_pin(dack_pin),
    .rx_done_evt(ev[4]), .tx_done_evt(ev[5]), .init_read_done(ev[6]), .ext_irq_src(ext_irq),
    .rx_disable(rx_disable), .tx_disable(tx_disable), .tx_desc_fetch(ev[7]), .irq(irq),
    .run_request(run_request), .init_request(init_request), .stopped(stopped),
    .rx_active(rx_active), .tx_active(tx_active), .tx_poll_now(tx_poll_now),
    .irq_mask_reg(irq_mask_reg));
  icsr_ext_regs_model part_u (.clk(clk), .reg_index(reg_index), .csr_wr(c_wr),
    .csr_rd(c_rd), .cfg_wr(b_wr), .cfg_rd(b_rd), .wdata(ext_wdata),
    .csr_rdata(csr_rd_d), .cfg_rdata(cfg_rd_d));
  // ---------------------------------------------------------------
  // access and check tasks
  // ---------------------------------------------------------------
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [1:0] s, input logic [15:0] d);
    @(negedge clk);
    host_sel = s;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk);
    host_wr = 1'b0;
  endtask
  task rd(input logic [1:0] s, input logic [15:0] e);
    @(negedge clk);
    host_sel = s;
    host_rd = 1'b1;
    @(negedge clk);
    host_rd = 1'b0;
    chk(host_rdata, e);
  endtask
  task pulse(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #700000;
    n_errors++;
    end_sim;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rd(PORT_INDEX, 16'h0000);
    rd(PORT_MAIN, 16'h0004);
    wr(PORT_INDEX, 16'h0003);
    rd(PORT_MAIN, 16'h0000);
    rd(2'h3, 16'h0000);
    $display("reset values done");
    wr(PORT_INDEX, 16'hFF85);
    rd(PORT_INDEX, 16'h0005);
    wr(PORT_MAIN, 16'h1234);
    wr(PORT_BUSCFG, 16'hABCD);
    rd(PORT_MAIN, 16'h1234);
    rd(PORT_MAIN, 16'h1234);
    rd(PORT_BUSCFG, 16'hABCD);
    $display("indexed access done");
    wr(PORT_INDEX, 16'h0003);
    wr(PORT_MAIN, 16'hFFFF);
    rd(PORT_MAIN, 16'h5F00);
    chk(irq_mask_reg, 16'h5F00);
    wr(PORT_INDEX, 16'h0000);
    pulse(4);
    rd(PORT_MAIN, 16'h0404);
    wr(PORT_INDEX, 16'h0003);
    wr(PORT_MAIN, 16'h0000);
    wr(PORT_INDEX, 16'h0000);
    rd(PORT_MAIN, 16'h0484);
    chk({15'h0000, irq}, 16'h0000);
    wr(PORT_MAIN, 16'h0040);
    chk({15'h0000, irq}, 16'h0001);
    rd(PORT_MAIN, 16'h04C4);
    wr(PORT_MAIN, 16'h0440);
    rd(PORT_MAIN, 16'h0044);
    chk({15'h0000, irq}, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      pulse(eb[i]);
      rd(PORT_MAIN, ef[i] | 16'h00C4);
      wr(PORT_MAIN, ef[i] | 16'h0040);
      rd(PORT_MAIN, 16'h0044);
    end
    $display("event flags done");
    pulse(0);
    repeat (1518) pulse(1);
    rd(PORT_MAIN, 16'h0044);
    pulse(1);
    rd(PORT_MAIN, 16'hC0C4);
    wr(PORT_MAIN, 16'h4040);
    pulse(2);
    repeat (260) @(negedge clk);
    rd(PORT_MAIN, 16'hA044);
    chk({15'h0000, irq}, 16'h0000);
    wr(PORT_MAIN, 16'h2040);
    pulse(2);
    repeat (100) @(negedge clk);
    col_pin = 1'b1;
    repeat (4) @(negedge clk);
    col_pin = 1'b0;
    repeat (200) @(negedge clk);
    rd(PORT_MAIN, 16'h0044);
    tp_mode = 1'b1;
    link_fail = 1'b1;
    tx_busy = 1'b1;
    @(negedge clk);
    tp_mode = 1'b0;
    rd(PORT_MAIN, 16'hA044);
    wr(PORT_MAIN, 16'h2040);
    dma_req = 1'b1;
    repeat (DMA_T + 5) @(negedge clk);
    rd(PORT_MAIN, 16'h88C4);
    dma_req = 1'b0;
    wr(PORT_MAIN, 16'h0840);
    dma_req = 1'b1;
    repeat (5) @(negedge clk);
    dack_pin = 1'b1;
    repeat (DMA_T + 5) @(negedge clk);
    rd(PORT_MAIN, 16'h0044);
    dma_req = 1'b0;
    dack_pin = 1'b0;
    $display("error flags done");
    wr(PORT_MAIN, 16'h0042);
    rd(PORT_MAIN, 16'h0062);
    wr(PORT_MAIN, 16'h0048);
    chk({15'h0000, tx_poll_now}, 16'h0000);
    ext_irq = 1'b1;
    rd(PORT_MAIN, 16'h00E2);
    chk({15'h0000, irq}, 16'h0001);
    wr(PORT_INDEX, 16'h0003);
    wr(PORT_MAIN, 16'h1000);
    wr(PORT_INDEX, 16'h0000);
    pulse(3);
    wr(PORT_MAIN, 16'h0004);
    rd(PORT_MAIN, 16'h0004);
    ext_irq = 1'b0;
    wr(PORT_INDEX, 16'h0003);
    rd(PORT_MAIN, 16'h1000);
    wr(PORT_INDEX, 16'h0000);
    tx_disable = 1'b0;
    wr(PORT_MAIN, 16'h0003);
    rd(PORT_MAIN, 16'h0003);
    chk({15'h0000, init_request}, 16'h0001);
    pulse(6);
    rd(PORT_MAIN, 16'h01B3);
    wr(PORT_MAIN, 16'h0108);
    chk({15'h0000, tx_poll_now}, 16'h0001);
    rd(PORT_MAIN, 16'h003B);
    pulse(7);
    chk({15'h0000, tx_poll_now}, 16'h0000);
    wr(PORT_MAIN, 16'h0007);
    rd(PORT_MAIN, 16'h0004);
    $display("run control done");
    end_sim;
  end
endmodule // test_indexed_csr_status_irq
